// ==== halfword_signed_load_store.sv ====
// Execution unit for halfword, signed byte and signed halfword transfers.
// Assumes the core presents register values with a one-cycle issue pulse and
// that the memory answers in the transfer cycle itself.
`timescale 1ns/1ps
`default_nettype none
`include "halfword_signed_load_store_consts.svh"
module halfword_signed_load_store (
    input wire logic clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic issue,
    input wire logic cond_pass,
    input wire logic [31:0] instr,
    input wire logic [31:0] instr_addr,
    input wire logic [31:0] base_value,
    input wire logic [31:0] index_value,
    input wire logic [31:0] src_value,
    output logic busy,
    output halfword_signed_load_store_pkg::cycle_t cycle_type,
    output logic mem_req,
    output logic mem_write,
    output logic [31:0] mem_addr,
    output logic [31:0] mem_wdata,
    input wire logic [31:0] mem_rdata,
    input wire logic mem_abort,
    output logic data_abort,
    output logic reg_we,
    output logic [3:0] reg_waddr,
    output logic [31:0] reg_wdata
);
    import halfword_signed_load_store_pkg::*;

    state_t state_reg;
    cycle_t cyc_reg;
    logic [31:0] instr_reg;
    logic [31:0] base_reg;
    logic [31:0] index_reg;
    logic [31:0] src_reg;
    logic [31:0] ld_reg;
    logic aborted_reg;
    logic endian_select_reg;
    logic abort_seen_reg;
    logic busy_reg;
    logic mem_req_reg;
    logic mem_write_reg;
    logic [31:0] mem_addr_reg;
    logic [31:0] mem_wdata_reg;
    logic data_abort_reg;
    logic reg_we_reg;
    logic [3:0] reg_waddr_reg;
    logic [31:0] reg_wdata_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;

    // Decode of the latched instruction.
    wire pre = instr_reg[`BIT_PRE];
    wire up = instr_reg[`BIT_UP];
    wire is_load = instr_reg[`BIT_LOAD];
    wire sgn = instr_reg[`BIT_SIGN];
    wire half = instr_reg[`BIT_HALF];
    wire [3:0] base_register = instr_reg[19:16];
    wire [3:0] rd = instr_reg[15:12];
    wire [31:0] imm_off = {24'h0, instr_reg[11:8], instr_reg[3:0]};
    wire [31:0] offset = instr_reg[`BIT_IMM] ? imm_off : index_reg;
    wire [31:0] mod_base = up ? base_reg + offset : base_reg - offset;
    wire [31:0] xfer_addr = pre ? mod_base : base_reg;
    // Post-indexed forms always write back; W only matters when pre-indexed.
    wire writeback = !pre || instr_reg[`BIT_WB];
    wire to_pc = rd == `PC_INDEX;

    // Issue: S=0,H=0 is not a transfer of this class and is ignored.
    wire form_ok = instr[`BIT_SIGN] || instr[`BIT_HALF];
    wire accept = issue && state_reg == ST_IDLE && cond_pass && form_ok;
    wire [31:0] base_in = (instr[19:16] == `PC_INDEX) ? instr_addr + `PC_BASE_ADJ : base_value;
    wire [31:0] src_in = (instr[15:12] == `PC_INDEX) ? instr_addr + `PC_STORE_ADJ : src_value;

    // Lane selection. Address bit 0 is not masked: a misaligned halfword
    // simply returns whatever the selected lane holds.
    wire [1:0] byte_sel = endian_select_reg ? ~mem_addr_reg[1:0] : mem_addr_reg[1:0];
    wire [7:0] lane_byte = mem_rdata[{byte_sel, 3'b000} +: 8];
    wire hi_half = mem_addr_reg[1] ^ endian_select_reg;
    wire [15:0] lane_half = hi_half ? mem_rdata[31:16] : mem_rdata[15:0];
    wire [31:0] sext_byte = {{24{lane_byte[7]}}, lane_byte};
    wire [31:0] sext_half = {{16{lane_half[15]}}, lane_half};
    wire [31:0] zext_half = {16'h0000, lane_half};
    wire [31:0] load_value = sgn ? (half ? sext_half : sext_byte) : zext_half;

    // Next-state and cycle-type selection.
    state_t state_next;
    cycle_t cyc_next;
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: state_next = accept ? ST_CALC : ST_IDLE;
            ST_CALC: state_next = ST_XFER;
            ST_XFER: state_next = is_load ? ST_INT : ST_IDLE;
            ST_INT: state_next = (to_pc && !aborted_reg) ? ST_FILL_N : ST_IDLE;
            ST_FILL_N: state_next = ST_FILL_S;
            ST_FILL_S: state_next = ST_IDLE;
            default: state_next = ST_IDLE;
        endcase
    end
    wire is_load_next = accept ? instr[`BIT_LOAD] : is_load;
    always_comb begin
        case (state_next)
            ST_CALC: cyc_next = is_load_next ? CYC_S : CYC_N;
            ST_XFER: cyc_next = CYC_N;
            ST_INT: cyc_next = CYC_I;
            ST_FILL_N: cyc_next = CYC_N;
            ST_FILL_S: cyc_next = CYC_S;
            default: cyc_next = CYC_I;
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_reg <= ST_IDLE;
            cyc_reg <= CYC_I;
            busy_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cyc_reg <= cyc_next;
            busy_reg <= state_next != ST_IDLE;
        end
    end

    // Operands are captured once so the core may move on after issue.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            instr_reg <= 32'h0000_0000;
            base_reg <= 32'h0000_0000;
            index_reg <= 32'h0000_0000;
            src_reg <= 32'h0000_0000;
        end else if (accept) begin
            instr_reg <= instr;
            base_reg <= base_in;
            index_reg <= index_value;
            src_reg <= src_in;
        end
    end

    // Memory request stands for exactly the transfer cycle.
    wire go_xfer = state_reg == ST_CALC;
    wire in_xfer = state_reg == ST_XFER;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            mem_req_reg <= 1'b0;
            mem_write_reg <= 1'b0;
            mem_addr_reg <= 32'h0000_0000;
            mem_wdata_reg <= 32'h0000_0000;
        end else begin
            mem_req_reg <= go_xfer;
            mem_write_reg <= go_xfer && !is_load;
            if (go_xfer) begin
                mem_addr_reg <= xfer_addr;
                mem_wdata_reg <= {src_reg[15:0], src_reg[15:0]};
            end
        end
    end

    // An abort cancels the base update and the destination load so the
    // instruction can be restarted from its original state.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ld_reg <= 32'h0000_0000;
            aborted_reg <= 1'b0;
            data_abort_reg <= 1'b0;
        end else begin
            data_abort_reg <= in_xfer && mem_abort;
            if (in_xfer) begin
                ld_reg <= load_value;
                aborted_reg <= mem_abort;
            end
        end
    end

    // Single register write port: base in the I cycle, destination after.
    wire wb_now = in_xfer && writeback && !mem_abort;
    wire dest_now = state_reg == ST_INT && !aborted_reg;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            reg_we_reg <= 1'b0;
            reg_waddr_reg <= 4'h0;
            reg_wdata_reg <= 32'h0000_0000;
        end else begin
            reg_we_reg <= wb_now || dest_now;
            if (wb_now) begin
                reg_waddr_reg <= base_register;
                reg_wdata_reg <= mod_base;
            end else if (dest_now) begin
                reg_waddr_reg <= rd;
                reg_wdata_reg <= ld_reg;
            end
        end
    end

    // APB slave: one wait-free access phase, error on unmapped offsets.
    wire hit_ctrl = paddr == `OFF_CTRL;
    wire hit_status = paddr == `OFF_STATUS;
    wire hit_last = paddr == `OFF_LAST_ADDR;
    wire hit = hit_ctrl || hit_status || hit_last;
    wire setup = psel && !penable;
    wire wr_take = psel && penable && pready_reg && pwrite;
    wire [31:0] rd_mux = hit_ctrl ? {31'h0, endian_select_reg} :
                         hit_status ? {30'h0, abort_seen_reg, busy_reg} :
                         hit_last ? mem_addr_reg : 32'h0000_0000;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end else begin
            pready_reg <= setup;
            pslverr_reg <= setup && !hit;
            prdata_reg <= setup ? rd_mux : 32'h0000_0000;
        end
    end
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            endian_select_reg <= `CTRL_RESET;
            abort_seen_reg <= 1'b0;
        end else begin
            if (wr_take && hit_ctrl)
                endian_select_reg <= pwdata[0];
            // A new abort wins over a write-one-to-clear in the same cycle.
            if (in_xfer && mem_abort)
                abort_seen_reg <= 1'b1;
            else if (wr_take && hit_status && pwdata[1])
                abort_seen_reg <= 1'b0;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign busy = busy_reg;
    assign cycle_type = cyc_reg;
    assign mem_req = mem_req_reg;
    assign mem_write = mem_write_reg;
    assign mem_addr = mem_addr_reg;
    assign mem_wdata = mem_wdata_reg;
    assign data_abort = data_abort_reg;
    assign reg_we = reg_we_reg;
    assign reg_waddr = reg_waddr_reg;
    assign reg_wdata = reg_wdata_reg;

    property p_cond_skip;
        @(posedge clk) disable iff (reset)
        state_reg == ST_IDLE && issue && !cond_pass |=> state_reg == ST_IDLE && !mem_req_reg;
    endproperty
    a_cond_skip: assert property (p_cond_skip) else $error("Failed condition still ran");

    property p_addr;
        @(posedge clk) disable iff (reset)
        go_xfer |=> mem_addr_reg == (pre ? (up ? base_reg + offset : base_reg - offset) : base_reg);
    endproperty
    a_addr: assert property (p_addr) else $error("Transfer address wrong");

    property p_wb;
        @(posedge clk) disable iff (reset)
        in_xfer && !pre && !mem_abort |=> reg_we_reg && reg_waddr_reg == base_register;
    endproperty
    a_wb: assert property (p_wb) else $error("Post-index writeback missing");

    property p_store_rep;
        @(posedge clk) disable iff (reset)
        mem_req_reg && mem_write_reg |-> mem_wdata_reg[31:16] == mem_wdata_reg[15:0];
    endproperty
    a_store_rep: assert property (p_store_rep) else $error("Store halves differ");

    property p_sbyte;
        @(posedge clk) disable iff (reset)
        state_reg == ST_INT && !aborted_reg && sgn && !half |=>
            reg_we_reg && reg_wdata_reg[31:8] == {24{reg_wdata_reg[7]}};
    endproperty
    a_sbyte: assert property (p_sbyte) else $error("Byte sign extension wrong");

    property p_shalf;
        @(posedge clk) disable iff (reset)
        state_reg == ST_INT && !aborted_reg && sgn && half |=>
            reg_wdata_reg[31:16] == {16{reg_wdata_reg[15]}};
    endproperty
    a_shalf: assert property (p_shalf) else $error("Halfword sign extension wrong");

    property p_uhalf;
        @(posedge clk) disable iff (reset)
        state_reg == ST_INT && !aborted_reg && !sgn |=> reg_wdata_reg[31:16] == 16'h0000;
    endproperty
    a_uhalf: assert property (p_uhalf) else $error("Unsigned top not cleared");

    property p_abort;
        @(posedge clk) disable iff (reset)
        in_xfer && mem_abort |=> data_abort_reg && !reg_we_reg ##1 !reg_we_reg;
    endproperty
    a_abort: assert property (p_abort) else $error("Abort did not cancel writes");

    property p_load_cycles;
        @(posedge clk) disable iff (reset)
        go_xfer && is_load |-> cyc_reg == CYC_S ##1 cyc_reg == CYC_N ##1 cyc_reg == CYC_I;
    endproperty
    a_load_cycles: assert property (p_load_cycles) else $error("Load cycle types wrong");

    property p_store_cycles;
        @(posedge clk) disable iff (reset)
        go_xfer && !is_load |-> cyc_reg == CYC_N ##1 cyc_reg == CYC_N ##1 state_reg == ST_IDLE;
    endproperty
    a_store_cycles: assert property (p_store_cycles) else $error("Store cycle types wrong");

    property p_imm_off;
        @(posedge clk) disable iff (reset)
        go_xfer && pre && up && instr_reg[`BIT_IMM] |=>
            mem_addr_reg == base_reg + {24'h00_0000, instr_reg[11:8], instr_reg[3:0]};
    endproperty
    a_imm_off: assert property (p_imm_off) else $error("Immediate offset wrong");

    property p_sub;
        @(posedge clk) disable iff (reset)
        go_xfer && pre && !up |=> mem_addr_reg + offset == base_reg;
    endproperty
    a_sub: assert property (p_sub) else $error("Down offset not subtracted");

    property p_pre_no_wb;
        @(posedge clk) disable iff (reset)
        in_xfer && pre && !instr_reg[`BIT_WB] |=> !reg_we_reg;
    endproperty
    a_pre_no_wb: assert property (p_pre_no_wb) else $error("Base written without writeback");

    property p_form;
        @(posedge clk) disable iff (reset)
        state_reg == ST_IDLE && issue && !instr[`BIT_SIGN] && !instr[`BIT_HALF] |=> state_reg == ST_IDLE;
    endproperty
    a_form: assert property (p_form) else $error("Foreign form was executed");

    property p_byte_lane;
        @(posedge clk) disable iff (reset)
        in_xfer && sgn && !half |=> ld_reg[7:0] == 8'($past(mem_rdata) >>
            (($past(endian_select_reg) ? 2'h3 - mem_addr_reg[1:0] : mem_addr_reg[1:0]) * 5'h08));
    endproperty
    a_byte_lane: assert property (p_byte_lane) else $error("Byte lane wrong");

    property p_half_lane;
        @(posedge clk) disable iff (reset)
        in_xfer && half |=> ld_reg[15:0] == ((mem_addr_reg[1] == $past(endian_select_reg)) ?
            $past(mem_rdata[15:0]) : $past(mem_rdata[31:16]));
    endproperty
    a_half_lane: assert property (p_half_lane) else $error("Halfword lane wrong");

    property p_pc_base;
        @(posedge clk) disable iff (reset)
        accept && instr[19:16] == `PC_INDEX |=> base_reg == $past(instr_addr) + `PC_BASE_ADJ;
    endproperty
    a_pc_base: assert property (p_pc_base) else $error("Program counter base wrong");

    property p_pc_store;
        @(posedge clk) disable iff (reset)
        accept && instr[15:12] == `PC_INDEX && !instr[`BIT_LOAD] |=>
            ##1 mem_wdata_reg[15:0] == 16'($past(instr_addr, 2) + `PC_STORE_ADJ);
    endproperty
    a_pc_store: assert property (p_pc_store) else $error("Stored program counter wrong");

    property p_pc_cycles;
        @(posedge clk) disable iff (reset)
        state_reg == ST_INT && to_pc && !aborted_reg |=>
            cyc_reg == CYC_N ##1 cyc_reg == CYC_S ##1 state_reg == ST_IDLE;
    endproperty
    a_pc_cycles: assert property (p_pc_cycles) else $error("Refill cycle types wrong");

    property p_abort_only;
        @(posedge clk) disable iff (reset)
        !(in_xfer && mem_abort) |=> !data_abort_reg;
    endproperty
    a_abort_only: assert property (p_abort_only) else $error("Trap without abort");
endmodule : halfword_signed_load_store
`default_nettype wire

// ==== halfword_signed_load_store_consts.svh ====
// Constants for the halfword and signed load/store execution unit.
// Assumes an APB slave with a 12-bit byte address and 32-bit data.
// Operation
// - Execute only when the condition passes; otherwise change nothing.
// - Immediate offset is instruction bits 11..8 joined above bits 3..0.
// - Up bit set adds the offset to the base; clear subtracts it.
// - Pre-index uses the modified base as address; post uses the old base.
// - Pre-index writes back only with W set; post-index always writes back.
// - Sign clear with halfword set is an unsigned halfword load or store.
// - Sign set picks signed byte (H=0) or signed halfword (H=1) loads.
// - Signed byte goes to bits 7..0, bits 31..8 copy byte bit 7.
// - Signed halfword goes to bits 15..0, bits 31..16 copy bit 15.
// - Unsigned halfword goes to bits 15..0 with bits 31..16 cleared.
// - Lane placement follows the endianness control.
// - Little-endian byte offset 0 uses bits 7..0, higher offsets higher lanes.
// - Big-endian byte offset 0 uses bits 31..24, higher offsets lower lanes.
// - Little-endian halfword: address bit 1 low takes 15..0, high takes 31..16.
// - Big-endian halfword: address bit 1 low takes 31..16, high takes 15..0.
// - Address bit 0 high on halfwords gives an undefined result.
// - Halfword store drives source bits 15..0 on both bus halves.
// - Program counter as base reads as instruction address plus 8.
// - Program counter stored by a halfword store reads as address plus 12.
// - Memory abort rejects a transfer and the data abort trap is taken.
// - Loads take S, N, I; loads to PC add N, S; stores take two N.
`ifndef HALFWORD_SIGNED_LOAD_STORE_CONSTS_SVH
`define HALFWORD_SIGNED_LOAD_STORE_CONSTS_SVH
`define OFF_CTRL 12'h000
`define OFF_STATUS 12'h004
`define OFF_LAST_ADDR 12'h008
`define CTRL_RESET 1'b0
`define BIT_PRE 24
`define BIT_UP 23
`define BIT_IMM 22
`define BIT_WB 21
`define BIT_LOAD 20
`define BIT_SIGN 6
`define BIT_HALF 5
`define PC_INDEX 4'hF
`define PC_BASE_ADJ 32'h0000_0008
`define PC_STORE_ADJ 32'h0000_000C
`endif

// ==== halfword_signed_load_store_pkg.sv ====
// Types for the halfword and signed load/store execution unit.
// Assumes nothing of its surroundings.
package halfword_signed_load_store_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_CALC = 3'b001,
        ST_XFER = 3'b010,
        ST_INT = 3'b011,
        ST_FILL_N = 3'b100,
        ST_FILL_S = 3'b101
    } state_t;
    typedef enum logic [1:0] {
        CYC_I = 2'b00,
        CYC_S = 2'b01,
        CYC_N = 2'b10
    } cycle_t;
endpackage : halfword_signed_load_store_pkg

// ==== mem_model.sv ====
// Behavioural memory and memory manager on the far side of the unit.
// Assumes one-cycle transfer requests, answered within the request cycle.
`timescale 1ns/1ps
`default_nettype none
module mem_model #(
    parameter logic [31:0] INIT = 32'h817F_02FE
) (
    input wire logic clk,
    input wire logic mem_req,
    input wire logic mem_write,
    input wire logic [31:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    input wire logic endian_big,
    input wire logic abort_en,
    output logic [31:0] mem_rdata,
    output logic mem_abort
);
    logic [31:0] mem [16];
    logic [31:0] last;
    logic hi;
    initial begin
        last = 32'h0;
        for (int i = 0; i < 16; i++) mem[i] = INIT;
    end
    assign hi = mem_addr[1] ^ endian_big;
    // The bus floats outside the transfer cycle, so never show the last value there.
    assign mem_rdata = mem_req ? mem[mem_addr[5:2]] : ~last;
    assign mem_abort = mem_req & abort_en;
    always @(posedge clk) begin
        if (mem_req) last <= mem_rdata;
        // Only the addressed half of the replicated store data is committed.
        if (mem_req && mem_write && !abort_en) begin
            if (hi) mem[mem_addr[5:2]][31:16] <= mem_wdata[31:16];
            else mem[mem_addr[5:2]][15:0] <= mem_wdata[15:0];
        end
    end
endmodule : mem_model
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking bench for the halfword and signed load/store unit.
// Assumes the memory model beside it and the register offsets of the constants header.
`timescale 1ns/1ps
`default_nettype none
`include "halfword_signed_load_store_consts.svh"
module tb_top;
    import halfword_signed_load_store_pkg::*;
    localparam logic [31:0] INIT = 32'h817F_02FE;
    logic clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, issue = 0, cond_pass = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, instr = 0, instr_addr = 0, base_value = 0, index_value = 0, src_value = 0;
    logic [31:0] prdata, mem_addr, mem_wdata, mem_rdata, reg_wdata, rd, maddr, mwd;
    logic pready, pslverr, busy, mem_req, mem_write, mem_abort, data_abort, reg_we, er;
    logic big_tb = 0, abort_en = 0;
    logic [3:0] reg_waddr;
    cycle_t cycle_type;
    logic [31:0] rf [16];
    logic [15:0] wm;
    int miscompares = 0, checks = 0, nwr, nreq, nab, cs, cn, ci, k, bg;
    halfword_signed_load_store dut_u (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .issue(issue), .cond_pass(cond_pass), .instr(instr),
        .instr_addr(instr_addr), .base_value(base_value), .index_value(index_value),
        .src_value(src_value), .busy(busy), .cycle_type(cycle_type), .mem_req(mem_req),
        .mem_write(mem_write), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
        .mem_abort(mem_abort), .data_abort(data_abort), .reg_we(reg_we), .reg_waddr(reg_waddr),
        .reg_wdata(reg_wdata));
    mem_model #(.INIT(INIT)) mem_u (.clk(clk), .mem_req(mem_req), .mem_write(mem_write),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .endian_big(big_tb), .abort_en(abort_en),
        .mem_rdata(mem_rdata), .mem_abort(mem_abort));
    initial begin
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        if (reg_we) begin
            rf[reg_waddr] = reg_wdata;
            wm[reg_waddr] = 1'b1;
            nwr++;
        end
        if (mem_req) begin
            maddr = mem_addr;
            mwd = mem_wdata;
            nreq++;
        end
        if (busy) begin
            if (cycle_type === CYC_S) cs++;
            else if (cycle_type === CYC_N) cn++;
            else if (cycle_type === CYC_I) ci++;
        end
        if (data_abort) nab++;
    end
    task automatic summarize;
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : summarize
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    function automatic logic [31:0] mk(input logic p, u, i, w, l, s, h, input logic [3:0] bn, dn,
        input logic [7:0] off);
        return {4'hE, 3'b000, p, u, i, w, l, bn, dn, off[7:4], 1'b1, s, h, 1'b1, off[3:0]};
    endfunction : mk
    function automatic logic [31:0] ld_exp(input logic [31:0] w, input logic [1:0] a,
        input logic b, s, h);
        logic [1:0] ln;
        logic [15:0] hw;
        ln = b ? ~a : a;
        if (!h) return {{24{w[ln * 8 + 7]}}, w[ln * 8 +: 8]};
        hw = (a[1] ^ b) ? w[31:16] : w[15:0];
        return s ? {{16{hw[15]}}, hw} : {16'h0000, hw};
    endfunction : ld_exp
    task automatic run(input logic [31:0] ins, ia, bv, iv, sv, input logic cp);
        nwr = 0; nreq = 0; nab = 0; cs = 0; cn = 0; ci = 0; wm = 16'h0000;
        @(posedge clk);
        issue <= 1'b1;
        cond_pass <= cp;
        instr <= ins;
        instr_addr <= ia;
        base_value <= bv;
        index_value <= iv;
        src_value <= sv;
        @(posedge clk);
        issue <= 1'b0;
        do begin
            @(posedge clk);
        end while (busy !== 1'b0);
        @(posedge clk);
    endtask : run
    initial begin
        #2ms;
        miscompares++;
        summarize();
    end
    initial begin
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        apb(0, `OFF_CTRL, 0);
        chk(rd, 32'h0);
        apb(0, 12'h00C, 0);
        chk({31'h0, er}, 32'h1);
        chk(rd, 32'h0);
        for (bg = 0; bg < 2; bg++) begin
            apb(1, `OFF_CTRL, 32'(bg));
            big_tb <= bg[0];
            apb(0, `OFF_CTRL, 0);
            chk(rd, 32'(bg));
            for (k = 0; k < 4; k++) begin
                run(mk(1, 1, 1, 0, 1, 1, 0, 2, 1, 8'(k)), 0, 32'h100, 0, 0, 1);
                chk(rf[1], ld_exp(INIT, 2'(k), bg[0], 1, 0));
                chk(maddr, 32'h100 + k);
            end
            for (k = 0; k < 4; k++) begin
                run(mk(1, 1, 1, 0, 1, k[0], 1, 2, 3, {6'h0, k[1], 1'b0}), 0, 32'h100, 0, 0, 1);
                chk(rf[3], ld_exp(INIT, {k[1], 1'b0}, bg[0], k[0], 1));
            end
            chk(32'(cs * 256 + cn * 16 + ci), 32'h111);
            run(mk(1, 1, 1, 0, 0, 0, 1, 2, 4, 8'h12 + 8'(bg * 8)), 0, 32'h100, 0, 32'h5555_ABCD, 1);
            chk(mwd, 32'hABCD_ABCD);
            chk(32'(cs * 256 + cn * 16 + ci), 32'h020);
            run(mk(1, 1, 1, 0, 1, 0, 1, 2, 3, 8'h12 + 8'(bg * 8)), 0, 32'h100, 0, 0, 1);
            chk(rf[3], 32'h0000_ABCD);
            run(mk(1, 1, 1, 0, 1, 0, 1, 2, 3, 8'h10 + 8'(bg * 8)), 0, 32'h100, 0, 0, 1);
            chk(rf[3], ld_exp(INIT, 2'b00, bg[0], 0, 1));
        end
        run(mk(1, 0, 0, 1, 1, 0, 1, 5, 6, 8'h07), 0, 32'h200, 32'h10, 0, 1);
        chk(maddr, 32'h1F0);
        chk(rf[5], 32'h1F0);
        run(mk(0, 1, 1, 0, 1, 0, 1, 5, 6, 8'h23), 0, 32'h200, 0, 0, 1);
        chk(maddr, 32'h200);
        chk(rf[5], 32'h223);
        run(mk(1, 1, 1, 0, 1, 0, 1, 5, 6, 8'h04), 0, 32'h200, 0, 0, 1);
        chk({16'h0, wm}, 32'h40);
        run(mk(1, 1, 1, 1, 1, 0, 1, 5, 6, 8'h04), 0, 32'h200, 0, 0, 0);
        chk(32'(nwr * 16 + nreq), 32'h0);
        run(mk(1, 1, 1, 0, 1, 0, 0, 5, 6, 8'h04), 0, 32'h200, 0, 0, 1);
        chk(32'(nwr * 16 + nreq), 32'h0);
        run(mk(1, 1, 1, 0, 1, 0, 1, 15, 6, 8'h04), 32'h300, 32'hDEAD_0000, 0, 0, 1);
        chk(maddr, 32'h30C);
        run(mk(1, 1, 1, 0, 0, 0, 1, 2, 15, 8'h00), 32'h400, 32'h120, 0, 32'h0, 1);
        chk(mwd, 32'h040C_040C);
        run(mk(1, 1, 1, 0, 1, 0, 1, 2, 15, 8'h00), 0, 32'h100, 0, 0, 1);
        chk(rf[15], ld_exp(INIT, 2'b00, big_tb, 0, 1));
        chk(32'(cs * 256 + cn * 16 + ci), 32'h221);
        abort_en <= 1'b1;
        run(mk(0, 1, 1, 0, 1, 1, 1, 2, 7, 8'h02), 0, 32'h104, 0, 0, 1);
        abort_en <= 1'b0;
        chk(32'(nwr * 16 + nab), 32'h1);
        apb(0, `OFF_STATUS, 0);
        chk(rd, 32'h2);
        apb(1, `OFF_STATUS, 32'h2);
        apb(0, `OFF_STATUS, 0);
        chk(rd, 32'h0);
        apb(0, `OFF_LAST_ADDR, 0);
        chk(rd, 32'h104);
        summarize();
    end
endmodule : tb_top
`default_nettype wire
